// ---- design/qdc_pkg.sv ----
// package: types and constants for the quadrature filter, decoder and position counter
package qdc_pkg;

	// filter: four-stage sample history, three agreeing samples to move the output
	localparam int HIST_DEPTH = 4;
	localparam int STABLE_SAMPLES = 3;
	localparam logic [3:0] HIST_RESET = 4'h0;
	localparam logic LEVEL_RESET = 1'b0;
	// edges after reset before the history holds only real samples
	localparam logic [2:0] FILL_RESET = 3'h0;
	localparam logic [2:0] FILL_FULL = 3'(HIST_DEPTH);

	// counter: widest variant sets the storage, the narrow variant masks it
	localparam int CNT_MAX_W = 16;
	localparam int CNT_W_DEFAULT = 16;
	localparam int CNT_W_BASIC = 12;
	localparam logic [15:0] COUNT_RESET = 16'h0000;

	// latency from a qualified input change to the counter, in clock periods
	localparam int MAX_LATENCY_CLK = 7;

	// quadrature phases as (a,b): 1=10 2=11 3=01 4=00, indexed 0..3
	localparam logic [1:0] PH_AB_1 = 2'h2;
	localparam logic [1:0] PH_AB_2 = 2'h3;
	localparam logic [1:0] PH_AB_3 = 2'h1;
	localparam logic [1:0] PH_AB_4 = 2'h0;
	localparam logic [1:0] PH_IDX_1 = 2'h0;
	localparam logic [1:0] PH_IDX_2 = 2'h1;
	localparam logic [1:0] PH_IDX_3 = 2'h2;
	localparam logic [1:0] PH_IDX_4 = 2'h3;

	typedef struct packed {
		logic a;
		logic b;
	} qdc_quad_t;

	// per-channel filter state
	typedef struct packed {
		logic [3:0] hist;
		logic [2:0] fill;
		logic level;
		logic settled;
	} qdc_filt_state_t;

	// decoder and counter state
	typedef struct packed {
		logic armed;
		qdc_quad_t prev;
		logic step_pend;
		logic up;
		logic [15:0] count;
		logic strobe;
		logic cas;
	} qdc_core_state_t;

	localparam qdc_quad_t QUAD_RESET = '{a: 1'b0, b: 1'b0};

endpackage : qdc_pkg

// ---- design/qdc_filter.sv ----
// one channel of the digital noise filter: synchroniser plus three-sample agreement
`timescale 1ns/100ps
module qdc_filter (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// raw channel from the pin
	input wire logic raw,
	// filtered channel
	output logic level,
	output logic settled
);

	qdc_pkg::qdc_filt_state_t st;
	qdc_pkg::qdc_filt_state_t next_st;
	logic agree;

	// hist[0] is the first synchroniser flop and feeds only hist[1]
	assign agree = (st.hist[1] == st.hist[2]) && (st.hist[2] == st.hist[3]);

	always_comb begin
		next_st = st;
		next_st.hist = {st.hist[2:0], raw};
		if (st.fill != qdc_pkg::FILL_FULL) begin
			next_st.fill = 3'(st.fill + 3'h1);
		end
		// the reset zeros must not pass for a settled low level, or the
		// decoder would adopt a false phase and count once the real level lands
		if (agree && (st.fill == qdc_pkg::FILL_FULL)) begin
			next_st.level = st.hist[3];
			next_st.settled = 1'b1;
		end
	end

	// history needs HIST_DEPTH edges before agreement means anything
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st.hist <= qdc_pkg::HIST_RESET;
			st.fill <= qdc_pkg::FILL_RESET;
			st.level <= qdc_pkg::LEVEL_RESET;
			st.settled <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	assign level = st.level;
	assign settled = st.settled;

endmodule : qdc_filter

// ---- design/qdc_core.sv ----
// quadrature decoder core: two channel filters, 4x decode, up/down position counter
`timescale 1ns/100ps
// Functional notes
// - each channel is sampled only on rising mclk edges.
// - each channel keeps a four-stage sample history shift register.
// - filtered level changes only after three equal consecutive samples.
// - spikes between edges and pulses under two clocks never pass the filter.
// - a qualified input change reaches the counter within seven clocks.
// - every edge on either filtered channel gives one count, four per cycle.
// - previous and present filtered state are compared each clock for count and direction.
// - phase order 10,11,01,00 (a leading) increments the counter.
// - reverse phase order (b leading) decrements by one per state change.
// - illegal transitions are not flagged; here they produce no count.
// - binary up/down counter, 12 or 16 bits, updated on rising edges.
// - the whole counter value is presented continuously on position.
// - counter wraps: all ones plus one is zero, zero minus one is all ones.
// - count strobe and direction are also driven to external outputs.
// - decoded count pulse is high half a clock, in the counter update cycle.
// - direction valid one clock before each pulse rise, held one clock after.
// - overflow or underflow emits a half-cycle cascade pulse.
module qdc_core #(
	parameter int WIDTH = qdc_pkg::CNT_W_DEFAULT
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// encoder channels from the pins
	input wire logic quad_in_a,
	input wire logic quad_in_b,
	// position to the downstream latch
	output logic [WIDTH-1:0] position,
	// decoder and cascade outputs
	output logic decoded_count_pulse,
	output logic cascade_count_pulse,
	output logic count_up
);

	localparam logic [16:0] ONE17 = 17'h00001;
	localparam logic [15:0] CNT_MASK = 16'((ONE17 << WIDTH) - ONE17);

	qdc_pkg::qdc_core_state_t st;
	qdc_pkg::qdc_core_state_t next_st;
	qdc_pkg::qdc_quad_t filt;
	logic settled_a;
	logic settled_b;
	logic step_valid;
	logic step_up;
	logic [16:0] stepped;

	// maps a filtered (a,b) pair to its phase index 0..3
	function automatic logic [1:0] phase_of(input qdc_pkg::qdc_quad_t q);
		logic [1:0] idx;
		idx = qdc_pkg::PH_IDX_4;
		case ({q.a, q.b})
			qdc_pkg::PH_AB_1: idx = qdc_pkg::PH_IDX_1;
			qdc_pkg::PH_AB_2: idx = qdc_pkg::PH_IDX_2;
			qdc_pkg::PH_AB_3: idx = qdc_pkg::PH_IDX_3;
			qdc_pkg::PH_AB_4: idx = qdc_pkg::PH_IDX_4;
			default: idx = qdc_pkg::PH_IDX_4;
		endcase
		return idx;
	endfunction : phase_of

	// returns {valid, up} for one previous/present pair
	function automatic logic [1:0] decode_step(input qdc_pkg::qdc_quad_t p,
		input qdc_pkg::qdc_quad_t c);
		logic [1:0] pi;
		logic [1:0] ci;
		logic [1:0] res;
		pi = phase_of(p);
		ci = phase_of(c);
		res = 2'h0;
		if (ci == 2'(pi + 2'h1)) begin
			res = 2'h3;
		end else if (ci == 2'(pi - 2'h1)) begin
			res = 2'h2;
		end
		// no change or a double jump: no count, nothing flagged
		return res;
	endfunction : decode_step

	// one counter step modulo the active width; returns {wrapped, next count}
	function automatic logic [16:0] count_step(input logic [15:0] cur, input logic up);
		logic [15:0] nxt;
		logic wrapped;
		if (up) begin
			nxt = 16'(cur + 16'h0001) & CNT_MASK;
			wrapped = (cur == CNT_MASK);
		end else begin
			nxt = 16'(cur - 16'h0001) & CNT_MASK;
			wrapped = (cur == qdc_pkg::COUNT_RESET);
		end
		return {wrapped, nxt};
	endfunction : count_step

	qdc_filter u_filt_a (
		.mclk(mclk),
		.rst_n(rst_n),
		.raw(quad_in_a),
		.level(filt.a),
		.settled(settled_a)
	);

	qdc_filter u_filt_b (
		.mclk(mclk),
		.rst_n(rst_n),
		.raw(quad_in_b),
		.level(filt.b),
		.settled(settled_b)
	);

	assign {step_valid, step_up} = decode_step(st.prev, filt);
	assign stepped = count_step(st.count, st.up);

	always_comb begin
		next_st = st;
		next_st.strobe = 1'b0;
		next_st.cas = 1'b0;
		next_st.step_pend = 1'b0;
		if (!st.armed) begin
			// adopt the first settled level as the starting phase without counting
			if (settled_a && settled_b) begin
				next_st.armed = 1'b1;
				next_st.prev = filt;
			end
		end else begin
			next_st.prev = filt;
			if (step_valid) begin
				// direction is set one clock ahead of the counter update
				next_st.step_pend = 1'b1;
				next_st.up = step_up;
			end
		end
		if (st.step_pend) begin
			// wrap flag and new count come from one step, so the pulses line up
			next_st.count = stepped[15:0];
			next_st.cas = stepped[16];
			next_st.strobe = 1'b1;
		end
	end

	// direction only changes on a new count, so it holds across each pulse
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st.armed <= 1'b0;
			st.prev <= qdc_pkg::QUAD_RESET;
			st.step_pend <= 1'b0;
			st.up <= 1'b1;
			st.count <= qdc_pkg::COUNT_RESET;
			st.strobe <= 1'b0;
			st.cas <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	assign position = st.count[WIDTH-1:0];
	assign count_up = st.up;
	// gated with the clock high phase to give the half-cycle pulse; the edge that
	// clears strobe can leave a narrow blip, so sample these rather than count edges
	assign decoded_count_pulse = st.strobe & mclk;
	assign cascade_count_pulse = st.cas & mclk;

endmodule : qdc_core

// ---- test/qdc_encoder_model.sv ----
// encoder model: walks the quadrature phases and makes short glitches
`timescale 1ns/100ps
module qdc_encoder_model (
	// clock
	input wire logic mclk,
	// channels
	output logic quad_in_a,
	output logic quad_in_b
);
	logic [1:0] idx = 2'h0;
	initial {quad_in_a, quad_in_b} = 2'h2;
	// phase index 0..3 gives (a,b) 10,11,01,00; hold n must be at least two clocks (three samples)
	task automatic step(input logic up, input int n);
		idx = up ? idx + 2'h1 : idx - 2'h1;
		@(posedge mclk);
		{quad_in_a, quad_in_b} <= {~idx[1], ^idx};
		repeat (n) @(posedge mclk);
	endtask : step
	task automatic glitch(input int n);
		@(posedge mclk);
		quad_in_a <= ~quad_in_a;
		repeat (n) @(posedge mclk);
		quad_in_a <= ~quad_in_a;
		repeat (8) @(posedge mclk);
	endtask : glitch
endmodule : qdc_encoder_model

// ---- test/qdc_core_checker.sv ----
// checker: counting and output timing relations at the decoder core ports
`timescale 1ns/100ps
module qdc_core_checker #(
	parameter int WIDTH = 16
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic quad_in_a,
	input wire logic quad_in_b,
	input wire logic [WIDTH-1:0] position,
	input wire logic decoded_count_pulse,
	input wire logic cascade_count_pulse,
	input wire logic count_up
);
	// pulses are gated with mclk high, so the falling edge is where they are seen
	default clocking cb @(negedge mclk); endclocking
	default disable iff (!rst_n);
	a_step_up: assert property (
		decoded_count_pulse && count_up |-> position == $past(position) + 1'b1) else $error("bad up");
	a_step_down: assert property (
		decoded_count_pulse && !count_up |-> position == $past(position) - 1'b1) else $error("bad dn");
	a_pos_hold: assert property (
		!decoded_count_pulse |-> $stable(position)) else $error("position moved");
	a_cas_wrap: assert property (
		cascade_count_pulse |-> decoded_count_pulse && position == (count_up ? '0 : '1))
		else $error("stray cascade");
	a_cas_miss: assert property (
		decoded_count_pulse && position == (count_up ? '0 : '1) |-> cascade_count_pulse)
		else $error("missing cascade");
	a_dir_setup: assert property (
		decoded_count_pulse |-> $stable(count_up)) else $error("late direction");
	a_dir_hold: assert property (
		decoded_count_pulse |=> $stable(count_up)) else $error("direction not held");
	a_no_spurious: assert property (
		$stable({quad_in_a, quad_in_b})[*8] |=> !decoded_count_pulse) else $error("spurious count");
	a_reset_clear: assert property (
		disable iff (1'b0) !rst_n |-> position == '0 && count_up) else $error("reset not clear");
endmodule : qdc_core_checker
bind qdc_core qdc_core_checker #(.WIDTH(WIDTH)) u_chk (.mclk(mclk), .rst_n(rst_n),
	.quad_in_a(quad_in_a), .quad_in_b(quad_in_b), .position(position), .count_up(count_up),
	.decoded_count_pulse(decoded_count_pulse), .cascade_count_pulse(cascade_count_pulse));

// ---- test/testbench.sv ----
// testbench: steps, wrap, glitches and reset on the decoder core
`timescale 1ns/100ps
module testbench;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic quad_in_a;
	logic quad_in_b;
	logic [15:0] position;
	logic decoded_count_pulse;
	logic cascade_count_pulse;
	logic count_up;
	int n_errors = 0;
	int total_checks = 0;
	int n_cas = 0;
	int n_cas12 = 0;
	int n_cnt = 0;
	int n_low = 0;
	logic [11:0] position12;
	logic cascade12;
	always #12.5 mclk = ~mclk;
	// looked at mid high phase: the zero-width blip as a pulse ends is no count
	always @(posedge mclk) begin
		#6;
		if (decoded_count_pulse === 1'b1) n_cnt++;
		if (cascade_count_pulse === 1'b1) n_cas++;
		if (cascade12 === 1'b1) n_cas12++;
	end
	// the pulses belong to the high phase only
	always @(negedge mclk) begin
		#6;
		if (decoded_count_pulse !== 1'b0 || cascade_count_pulse !== 1'b0) n_low++;
	end
	qdc_encoder_model enc (.mclk(mclk), .quad_in_a(quad_in_a), .quad_in_b(quad_in_b));
	qdc_core #(.WIDTH(16)) DUT (.mclk(mclk), .rst_n(rst_n), .quad_in_a(quad_in_a),
		.quad_in_b(quad_in_b), .position(position), .decoded_count_pulse(decoded_count_pulse),
		.cascade_count_pulse(cascade_count_pulse), .count_up(count_up));
	qdc_core #(.WIDTH(12)) DUT_12 (.mclk(mclk), .rst_n(rst_n), .quad_in_a(quad_in_a),
		.quad_in_b(quad_in_b), .position(position12), .decoded_count_pulse(),
		.cascade_count_pulse(cascade12), .count_up());
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: %h vs %h", $time, seen, exp);
		end
	endtask : chk
	task automatic end_sim();
		if (n_errors == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_sim
	task automatic t_up();
		repeat (4) enc.step(1'b1, 4);
		repeat (3) @(posedge mclk);
		#7;
		chk(position, 16'h0004);
		chk(16'(count_up), 16'h0001);
		chk(16'(n_cnt), 16'h0004);
	endtask : t_up
	task automatic t_wrap();
		repeat (6) enc.step(1'b0, 4);
		repeat (8) @(posedge mclk);
		chk(position, 16'hFFFE);
		chk(16'(position[7:0]), 16'h00FE);
		chk(16'(position12), 16'h0FFE);
		chk(16'(count_up), 16'h0000);
		chk(16'(n_cas), 16'h0001);
		chk(16'(n_cas12), 16'h0001);
		repeat (3) enc.step(1'b1, 4);
		repeat (8) @(posedge mclk);
		chk(position, 16'h0001);
		chk(16'(position12), 16'h0001);
		chk(16'(n_cas), 16'h0002);
		chk(16'(n_cas12), 16'h0002);
		chk(16'(n_cnt), 16'h000D);
	endtask : t_wrap
	// one and two sample pulses stay below the three agreeing samples
	task automatic t_glitch();
		enc.glitch(1);
		enc.glitch(2);
		chk(position, 16'h0001);
		chk(16'(n_cnt), 16'h000D);
	endtask : t_glitch
	task automatic t_reset();
		@(posedge mclk);
		rst_n <= 1'b0;
		#2;
		chk(position, 16'h0000);
		chk(16'(position12), 16'h0000);
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (12) @(posedge mclk);
		chk(position, 16'h0000);
		chk(16'(n_cnt), 16'h000D);
		enc.step(1'b1, 12);
		chk(position, 16'h0001);
		chk(16'(n_cnt), 16'h000E);
		chk(16'(n_low), 16'h0000);
	endtask : t_reset
	initial begin
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (8) @(posedge mclk);
		t_up();
		t_wrap();
		t_glitch();
		t_reset();
		end_sim();
	end
endmodule : testbench
